// ---- rtl/debug_comparator_range_trace.sv ----
// Contract
// - high data register bits give expected data bus bits 15..8, A and C only
// - low data register bits give expected data bus bits 7..0, A and C only
// - data registers readable always, writable only while not armed
// - mask 0 skips a bit; mask 1 compares, equal or differing per invert
// - AB range uses A data, mask and direction; B's ignored
// - CD range uses C data, mask; C direction only untagged; D ignored
// - width compare controls have no effect on ranges
// - range tagging follows A and C tag controls; B and D ignored
// - range halt requests come from A and C halt controls only
// - tagged ranges resolve only to word boundaries
// - inside range needs address within both limits in the same cycle
// - inside range word access triggers only if aligned address inside
// - outside range accepts below lower or above upper limit alone
// - outside range word access triggers only if aligned address outside
// - interrupt vector fetches never give a tag hit
// - loop mode stores flow changes, skips source equal to last stored
// - loop mode still stores repeated destinations and vectors
// - detail mode stores address, data and width/direction info byte
// - detail skips free and fetch cycles, may be limited by C-D window
// - executed-PC mode stores every executed opcode address
`timescale 1ns/1ps
module debug_comparator_range_trace
	import debug_unit_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic mon_valid_i,
	input wire logic [ADDR_W-1:0] mon_addr_i,
	input wire logic [DATA_W-1:0] mon_data_i,
	input wire logic mon_write_i,
	input wire logic mon_word_i,
	input wire logic mon_fetch_i,
	input wire logic mon_free_i,
	input wire logic mon_vector_i,
	input wire logic cof_i,
	input wire logic [1:0] cof_kind_i,
	input wire logic [ADDR_W-1:0] cof_addr_i,
	input wire logic exec_i,
	input wire logic [ADDR_W-1:0] exec_pc_i,
	output logic halt_o,
	output logic tag_hit_o,
	output logic armed_o,
	output logic trace_valid_o,
	output logic [ADDR_W-1:0] trace_addr_o,
	output logic [DATA_W-1:0] trace_data_o,
	output logic [7:0] trace_info_o
);

	function automatic logic data_ok(input logic [DATA_W-1:0] bus,
		input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] mask,
		input logic inv);
		if (inv) begin
			data_ok = ((~(bus ^ exp)) & mask) == DATA_RESET;
		end else begin
			data_ok = ((bus ^ exp) & mask) == DATA_RESET;
		end
	endfunction : data_ok

	function automatic logic dir_ok(input logic [7:0] ctl, input logic wr);
		dir_ok = !ctl[CTL_DIR_EN] || (ctl[CTL_READ] == !wr);
	endfunction : dir_ok

	function automatic logic in_range(input logic [ADDR_W-1:0] a,
		input logic [ADDR_W-1:0] lo, input logic [ADDR_W-1:0] hi,
		input logic words);
		if (words) begin
			in_range = a[ADDR_W-1:1] >= lo[ADDR_W-1:1] &&
				a[ADDR_W-1:1] <= hi[ADDR_W-1:1];
		end else begin
			in_range = a >= lo && a <= hi;
		end
	endfunction : in_range

	logic [7:0] ctl_reg [4];
	logic [ADDR_W-1:0] addr_reg [4];
	logic [DATA_W-1:0] data_reg [2];
	logic [DATA_W-1:0] mask_reg [2];
	logic [7:0] pairing_reg;
	logic [7:0] trace_reg;
	logic armed_reg;
	logic select_reg;
	logic ack_reg;
	logic [31:0] rdat_reg;
	logic [31:0] rd_next;
	logic halt_reg;
	logic tag_reg;
	logic [15:0] count_reg;
	logic [ADDR_W-1:0] background_reg;
	logic tvalid_reg;
	logic [ADDR_W-1:0] taddr_reg;
	logic [DATA_W-1:0] tdata_reg;
	logic [7:0] tinfo_reg;

	logic req;
	logic wr;
	logic [5:0] idx;
	logic [31:0] addr_merge;
	logic [3:0] cmp_raw;
	logic [3:0] cmp_hit;
	logic [3:0] cmp_tag;
	logic [1:0] pair_on;
	logic [1:0] pair_in;
	logic [1:0] pair_hit;
	logic [1:0] pair_tag;
	logic halt_next;
	logic tag_next;
	trace_mode_t mode;
	logic [1:0] window;
	logic cd_inside;
	logic store;
	logic [ADDR_W-1:0] taddr_next;
	logic [DATA_W-1:0] tdata_next;
	logic [7:0] tinfo_next;

	assign req = wb_cyc_i && wb_stb_i && !ack_reg;
	assign wr = req && wb_we_i;
	assign idx = wb_adr_i[7:2];
	assign mode = trace_mode_t'(trace_reg[TRC_MODE_LSB +: 2]);
	assign window = trace_reg[TRC_WIN_LSB +: 2];

	assign wb_ack_o = ack_reg;
	assign wb_dat_o = rdat_reg;
	assign halt_o = halt_reg;
	assign tag_hit_o = tag_reg;
	assign armed_o = armed_reg;
	assign trace_valid_o = tvalid_reg;
	assign trace_addr_o = taddr_reg;
	assign trace_data_o = tdata_reg;
	assign trace_info_o = tinfo_reg;

	// bus slave: every access answered one cycle later, unmapped reads zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
			rdat_reg <= 32'h0000_0000;
		end else begin
			ack_reg <= req;
			if (req) begin
				rdat_reg <= rd_next;
			end
		end
	end

	always_comb begin
		rd_next = 32'h0000_0000;
		if (idx[5:2] == IDX_CTL[5:2]) begin
			rd_next[7:0] = ctl_reg[idx[1:0]];
		end else if (idx[5:2] == IDX_ADDR[5:2]) begin
			rd_next[ADDR_W-1:0] = addr_reg[idx[1:0]];
		end else begin
			case (idx)
				IDX_PAIRING: rd_next[7:0] = pairing_reg;
				IDX_TRACE: rd_next[7:0] = trace_reg;
				IDX_ARM: rd_next[0] = armed_reg;
				IDX_SELECT: rd_next[0] = select_reg;
				IDX_DATA_HIGH: rd_next[7:0] = data_reg[select_reg][15:8];
				IDX_DATA_LOW: rd_next[7:0] = data_reg[select_reg][7:0];
				IDX_MASK_HIGH: rd_next[7:0] = mask_reg[select_reg][15:8];
				IDX_MASK_LOW: rd_next[7:0] = mask_reg[select_reg][7:0];
				IDX_STATUS: begin
					rd_next[STAT_ARMED] = armed_reg;
					rd_next[STAT_HALT] = halt_reg;
					rd_next[STAT_TAG] = tag_reg;
					rd_next[STAT_COUNT_LSB +: 16] = count_reg;
				end
				default: rd_next = 32'h0000_0000;
			endcase
		end
	end

	always_comb begin
		addr_merge = {9'h000, addr_reg[idx[1:0]]};
		for (int b = 0; b < 3; b++) begin
			if (wb_sel_i[b]) begin
				addr_merge[8*b +: 8] = wb_dat_i[8*b +: 8];
			end
		end
	end

	// comparator controls and addresses
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int i = 0; i < 4; i++) begin
				ctl_reg[i] <= CTL_RESET;
				addr_reg[i] <= ADDR_RESET;
			end
		end else if (wr && idx[5:2] == IDX_CTL[5:2]) begin
			if (wb_sel_i[0]) begin
				ctl_reg[idx[1:0]] <= wb_dat_i[7:0];
			end
		end else if (wr && idx[5:2] == IDX_ADDR[5:2]) begin
			addr_reg[idx[1:0]] <= addr_merge[ADDR_W-1:0];
		end
	end

	// mode, trace, arm and data register select
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pairing_reg <= BYTE_RESET;
			trace_reg <= BYTE_RESET;
			armed_reg <= 1'b0;
			select_reg <= 1'b0;
		end else if (wr && wb_sel_i[0]) begin
			case (idx)
				IDX_PAIRING: pairing_reg <= wb_dat_i[7:0];
				IDX_TRACE: trace_reg <= wb_dat_i[7:0];
				IDX_ARM: armed_reg <= wb_dat_i[0];
				IDX_SELECT: select_reg <= wb_dat_i[0];
				default: armed_reg <= armed_reg;
			endcase
		end
	end

	// data registers exist for A and C only; armed writes are dropped
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			data_reg[0] <= DATA_RESET;
			data_reg[1] <= DATA_RESET;
		end else if (wr && wb_sel_i[0] && !armed_reg) begin
			if (idx == IDX_DATA_HIGH) begin
				data_reg[select_reg][15:8] <= wb_dat_i[7:0];
			end else if (idx == IDX_DATA_LOW) begin
				data_reg[select_reg][7:0] <= wb_dat_i[7:0];
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mask_reg[0] <= MASK_RESET;
			mask_reg[1] <= MASK_RESET;
		end else if (wr && wb_sel_i[0]) begin
			if (idx == IDX_MASK_HIGH) begin
				mask_reg[select_reg][15:8] <= wb_dat_i[7:0];
			end else if (idx == IDX_MASK_LOW) begin
				mask_reg[select_reg][7:0] <= wb_dat_i[7:0];
			end
		end
	end

	// comparators, single and paired
	always_comb begin
		halt_next = 1'b0;
		tag_next = 1'b0;
		for (int i = 0; i < 4; i++) begin
			cmp_raw[i] = mon_valid_i && ctl_reg[i][CTL_ENABLE] &&
				mon_addr_i == addr_reg[i] &&
				dir_ok(ctl_reg[i], mon_write_i) &&
				(!ctl_reg[i][CTL_WIDTH_EN] ||
				ctl_reg[i][CTL_WIDTH_WORD] == mon_word_i) &&
				(i[0] || data_ok(mon_data_i, data_reg[i/2], mask_reg[i/2],
				ctl_reg[i][CTL_INVERT]));
			// vector fetches are kept out of every tag
			cmp_tag[i] = cmp_raw[i] && ctl_reg[i][CTL_TAG] &&
				mon_fetch_i && !mon_vector_i;
			cmp_hit[i] = cmp_raw[i] && !ctl_reg[i][CTL_TAG];
		end
		for (int p = 0; p < 2; p++) begin
			// both enables needed; one alone leaves the pair silent
			pair_on[p] = pairing_reg[PAIR_AB_RANGE + p] &&
				ctl_reg[2*p][CTL_ENABLE] &&
				ctl_reg[2*p+1][CTL_ENABLE];
			pair_in[p] = in_range(mon_addr_i, addr_reg[2*p], addr_reg[2*p+1],
				ctl_reg[2*p][CTL_TAG]);
			if (pairing_reg[PAIR_AB_OUTSIDE + p]) begin
				pair_in[p] = !pair_in[p];
			end
			// width controls never enter; direction only from the lower one
			pair_in[p] = pair_in[p] && mon_valid_i && pair_on[p] &&
				data_ok(mon_data_i, data_reg[p], mask_reg[p],
				ctl_reg[2*p][CTL_INVERT]) &&
				((p == 1 && ctl_reg[2*p][CTL_TAG]) ||
				dir_ok(ctl_reg[2*p], mon_write_i));
			pair_tag[p] = pair_in[p] && ctl_reg[2*p][CTL_TAG] &&
				mon_fetch_i && !mon_vector_i;
			pair_hit[p] = pair_in[p] && !ctl_reg[2*p][CTL_TAG];
			if (pairing_reg[PAIR_AB_RANGE + p]) begin
				cmp_hit[2*p +: 2] = 2'b00;
				cmp_tag[2*p +: 2] = 2'b00;
			end
			halt_next = halt_next || ((pair_hit[p] || pair_tag[p]) &&
				ctl_reg[2*p][CTL_HALT]);
			tag_next = tag_next || pair_tag[p];
		end
		for (int i = 0; i < 4; i++) begin
			halt_next = halt_next || ((cmp_hit[i] || cmp_tag[i]) &&
				ctl_reg[i][CTL_HALT]);
			tag_next = tag_next || cmp_tag[i];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			halt_reg <= 1'b0;
			tag_reg <= 1'b0;
		end else begin
			halt_reg <= armed_reg && halt_next;
			tag_reg <= armed_reg && tag_next;
		end
	end

	// trace capture selection
	always_comb begin
		cd_inside = in_range(mon_addr_i, addr_reg[2], addr_reg[3], 1'b0);
		store = 1'b0;
		taddr_next = ADDR_RESET;
		tdata_next = DATA_RESET;
		tinfo_next = BYTE_RESET;
		case (mode)
			TRACE_NORMAL: begin
				store = cof_i;
				taddr_next = cof_addr_i;
			end
			TRACE_LOOP: begin
				store = cof_i && (cof_kind_i != COF_SOURCE ||
					cof_addr_i != background_reg);
				taddr_next = cof_addr_i;
			end
			TRACE_DETAIL: begin
				store = mon_valid_i && !mon_free_i && !mon_fetch_i &&
					(window == WIN_INSIDE ? cd_inside :
					window == WIN_OUTSIDE ? !cd_inside : 1'b1);
				taddr_next = mon_addr_i;
				tdata_next = mon_data_i;
				tinfo_next[INFO_WORD] = mon_word_i;
				tinfo_next[INFO_WRITE] = mon_write_i;
			end
			TRACE_PC: begin
				store = exec_i;
				taddr_next = exec_pc_i;
			end
			default: store = 1'b0;
		endcase
		store = store && armed_reg && trace_reg[TRC_ENABLE];
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tvalid_reg <= 1'b0;
			taddr_reg <= ADDR_RESET;
			tdata_reg <= DATA_RESET;
			tinfo_reg <= BYTE_RESET;
		end else begin
			tvalid_reg <= store;
			if (store) begin
				taddr_reg <= taddr_next;
				tdata_reg <= tdata_next;
				tinfo_reg <= tinfo_next;
			end
		end
	end

	// copy of the last stored address for loop filtering
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			background_reg <= ADDR_RESET;
		end else if (store) begin
			background_reg <= taddr_next;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			count_reg <= COUNT_RESET;
		end else if (store) begin
			count_reg <= count_reg + 16'h0001;
		end
	end

	data_lock_a: assert property (@(posedge clk_i) disable iff (rst_i)
		wr && armed_reg && (idx == IDX_DATA_HIGH || idx == IDX_DATA_LOW)
		|=> data_reg[0] == $past(data_reg[0]) &&
		data_reg[1] == $past(data_reg[1]))
		else $error("data register changed while armed");

	data_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
		wr && !armed_reg && wb_sel_i[0] && idx == IDX_DATA_LOW
		|=> data_reg[$past(select_reg)][7:0] == $past(wb_dat_i[7:0]))
		else $error("data low write lost");

	inside_pair_a: assert property (@(posedge clk_i) disable iff (rst_i)
		pair_hit[0] && !pairing_reg[PAIR_AB_OUTSIDE] && !ctl_reg[0][CTL_TAG]
		|-> mon_addr_i >= addr_reg[0] && mon_addr_i <= addr_reg[1])
		else $error("inside range hit outside limits");

	outside_pair_a: assert property (@(posedge clk_i) disable iff (rst_i)
		pair_hit[1] && pairing_reg[PAIR_CD_OUTSIDE] && !ctl_reg[2][CTL_TAG]
		|-> mon_addr_i < addr_reg[2] || mon_addr_i > addr_reg[3])
		else $error("outside range hit inside limits");

	vector_tag_a: assert property (@(posedge clk_i) disable iff (rst_i)
		mon_vector_i |=> !tag_hit_o)
		else $error("tag hit on vector fetch");

	loop_filter_a: assert property (@(posedge clk_i) disable iff (rst_i)
		armed_reg && trace_reg[TRC_ENABLE] && mode == TRACE_LOOP && cof_i &&
		cof_kind_i == COF_SOURCE && cof_addr_i == background_reg
		|=> !trace_valid_o)
		else $error("duplicate source stored");

	detail_info_a: assert property (@(posedge clk_i) disable iff (rst_i)
		store && mode == TRACE_DETAIL
		|=> trace_valid_o && trace_info_o[INFO_WRITE] == $past(mon_write_i) &&
		trace_info_o[INFO_WORD] == $past(mon_word_i) &&
		trace_data_o == $past(mon_data_i))
		else $error("detail entry wrong");

	detail_skip_a: assert property (@(posedge clk_i) disable iff (rst_i)
		mode == TRACE_DETAIL && (mon_free_i || mon_fetch_i) |=> !trace_valid_o)
		else $error("free or fetch cycle traced");

	pc_trace_a: assert property (@(posedge clk_i) disable iff (rst_i)
		armed_reg && trace_reg[TRC_ENABLE] && mode == TRACE_PC && exec_i
		|=> trace_valid_o && trace_addr_o == $past(exec_pc_i))
		else $error("executed pc not stored");

	range_halt_a: assert property (@(posedge clk_i) disable iff (rst_i)
		armed_reg && pairing_reg[PAIR_AB_RANGE] && pairing_reg[PAIR_CD_RANGE] &&
		!ctl_reg[0][CTL_HALT] && !ctl_reg[2][CTL_HALT] |=> !halt_o)
		else $error("halt from ignored comparator");

endmodule : debug_comparator_range_trace

// ---- rtl/debug_unit_pkg.sv ----
package debug_unit_pkg;
	localparam int ADDR_W = 23;
	localparam int DATA_W = 16;
	// word indices; byte address is four times the index
	localparam logic [5:0] IDX_CTL = 6'h20;
	localparam logic [5:0] IDX_ADDR = 6'h24;
	localparam logic [5:0] IDX_PAIRING = 6'h28;
	localparam logic [5:0] IDX_TRACE = 6'h29;
	localparam logic [5:0] IDX_ARM = 6'h2a;
	localparam logic [5:0] IDX_SELECT = 6'h2b;
	localparam logic [5:0] IDX_DATA_HIGH = 6'h2c;
	localparam logic [5:0] IDX_DATA_LOW = 6'h2d;
	localparam logic [5:0] IDX_MASK_HIGH = 6'h2e;
	localparam logic [5:0] IDX_MASK_LOW = 6'h2f;
	localparam logic [5:0] IDX_STATUS = 6'h30;
	// comparator control bits
	localparam int CTL_ENABLE = 0;
	localparam int CTL_DIR_EN = 1;
	localparam int CTL_READ = 2;
	localparam int CTL_WIDTH_EN = 3;
	localparam int CTL_WIDTH_WORD = 4;
	localparam int CTL_HALT = 5;
	localparam int CTL_TAG = 6;
	localparam int CTL_INVERT = 7;
	// pairing control bits
	localparam int PAIR_AB_RANGE = 0;
	localparam int PAIR_CD_RANGE = 1;
	localparam int PAIR_AB_OUTSIDE = 2;
	localparam int PAIR_CD_OUTSIDE = 3;
	// trace control fields
	localparam int TRC_MODE_LSB = 0;
	localparam int TRC_WIN_LSB = 2;
	localparam int TRC_ENABLE = 7;
	localparam logic [1:0] WIN_INSIDE = 2'h1;
	localparam logic [1:0] WIN_OUTSIDE = 2'h2;
	// change-of-flow kinds
	localparam logic [1:0] COF_SOURCE = 2'h0;
	localparam logic [1:0] COF_DEST = 2'h1;
	localparam logic [1:0] COF_VECTOR = 2'h2;
	// information byte bits
	localparam int INFO_WORD = 0;
	localparam int INFO_WRITE = 1;
	// status bits
	localparam int STAT_ARMED = 0;
	localparam int STAT_HALT = 1;
	localparam int STAT_TAG = 2;
	localparam int STAT_COUNT_LSB = 16;
	// values after reset
	localparam logic [7:0] CTL_RESET = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_RESET = 23'h00_0000;
	localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;
	localparam logic [DATA_W-1:0] MASK_RESET = 16'h0000;
	localparam logic [7:0] BYTE_RESET = 8'h00;
	localparam logic [15:0] COUNT_RESET = 16'h0000;
	typedef enum logic [1:0] {
		TRACE_NORMAL, TRACE_LOOP, TRACE_DETAIL, TRACE_PC
	} trace_mode_t;
endpackage : debug_unit_pkg

// ---- verif/core_bus_model.sv ----
`timescale 1ns/1ps
module core_bus_model
	import debug_unit_pkg::*;
(
	input wire logic clk_i,
	output logic mon_valid_o,
	output logic [ADDR_W-1:0] mon_addr_o,
	output logic [DATA_W-1:0] mon_data_o,
	output logic mon_write_o,
	output logic mon_word_o,
	output logic mon_fetch_o,
	output logic mon_free_o,
	output logic mon_vector_o,
	output logic cof_o,
	output logic [1:0] cof_kind_o,
	output logic [ADDR_W-1:0] cof_addr_o,
	output logic exec_o,
	output logic [ADDR_W-1:0] exec_pc_o
);
	initial begin
		{mon_valid_o, cof_o, exec_o} = 3'h0;
		mon_addr_o = 23'h00_0000;
		mon_data_o = 16'h0000;
		{mon_vector_o, mon_free_o, mon_fetch_o, mon_word_o, mon_write_o} = 5'h00;
		cof_kind_o = 2'h0;
		cof_addr_o = 23'h00_0000;
		exec_pc_o = 23'h00_0000;
	end

	// outside a cycle every qualifier flips, so stale values never help
	task automatic bus_cycle(input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] d, input logic [4:0] f);
		@(posedge clk_i);
		mon_valid_o <= 1'b1;
		mon_addr_o <= a;
		mon_data_o <= d;
		{mon_vector_o, mon_free_o, mon_fetch_o, mon_word_o, mon_write_o} <= f;
		@(posedge clk_i);
		mon_valid_o <= 1'b0;
		mon_addr_o <= ~a;
		mon_data_o <= ~d;
		{mon_vector_o, mon_free_o, mon_fetch_o, mon_word_o, mon_write_o} <= ~f;
	endtask : bus_cycle

	task automatic cof_event(input logic [1:0] k, input logic [ADDR_W-1:0] a);
		@(posedge clk_i);
		cof_o <= 1'b1;
		cof_kind_o <= k;
		cof_addr_o <= a;
		@(posedge clk_i);
		cof_o <= 1'b0;
		cof_kind_o <= ~k;
		cof_addr_o <= ~a;
	endtask : cof_event

	task automatic exec_op(input logic [ADDR_W-1:0] pc);
		@(posedge clk_i);
		exec_o <= 1'b1;
		exec_pc_o <= pc;
		@(posedge clk_i);
		exec_o <= 1'b0;
		exec_pc_o <= ~pc;
	endtask : exec_op
endmodule : core_bus_model

// ---- verif/testbench.sv ----
`timescale 1ns/1ps
module testbench;
	import debug_unit_pkg::*;
	localparam logic [31:0] ZERO = 32'h0000_0000;
	localparam logic [31:0] ONE = 32'h0000_0001;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0000_0000;
	logic [31:0] wb_dat_o;
	logic wb_ack_o, halt_o, tag_hit_o, armed_o, trace_valid_o;
	logic [ADDR_W-1:0] trace_addr_o, mon_addr, cof_addr, exec_pc;
	logic [DATA_W-1:0] trace_data_o, mon_data;
	logic [7:0] trace_info_o;
	logic mon_valid, mon_write, mon_word, mon_fetch, mon_free, mon_vector;
	logic cof_ev, exec_ev;
	logic [1:0] cof_kind, k;
	int fail_count = 0;
	int total_checks = 0;
	int seed = 41;
	logic [31:0] rd;
	logic [7:0] dh, dl;
	logic [ADDR_W-1:0] lo, hi, a, last;
	logic [DATA_W-1:0] d, msk;
	logic [4:0] f;
	logic e, inv, outside;
	logic [5:0] ridx [4] = '{IDX_DATA_HIGH, IDX_DATA_LOW, IDX_STATUS, 6'h3f};

	always #20 clk_i = ~clk_i;

	core_bus_model i_model (.clk_i(clk_i), .mon_valid_o(mon_valid),
		.mon_addr_o(mon_addr), .mon_data_o(mon_data), .mon_write_o(mon_write),
		.mon_word_o(mon_word), .mon_fetch_o(mon_fetch), .mon_free_o(mon_free),
		.mon_vector_o(mon_vector), .cof_o(cof_ev), .cof_kind_o(cof_kind),
		.cof_addr_o(cof_addr), .exec_o(exec_ev), .exec_pc_o(exec_pc));

	debug_comparator_range_trace i_dut (.clk_i(clk_i), .rst_i(rst_i),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .mon_valid_i(mon_valid),
		.mon_addr_i(mon_addr), .mon_data_i(mon_data), .mon_write_i(mon_write),
		.mon_word_i(mon_word), .mon_fetch_i(mon_fetch), .mon_free_i(mon_free),
		.mon_vector_i(mon_vector), .cof_i(cof_ev), .cof_kind_i(cof_kind),
		.cof_addr_i(cof_addr), .exec_i(exec_ev), .exec_pc_i(exec_pc),
		.halt_o(halt_o), .tag_hit_o(tag_hit_o), .armed_o(armed_o),
		.trace_valid_o(trace_valid_o), .trace_addr_o(trace_addr_o),
		.trace_data_o(trace_data_o), .trace_info_o(trace_info_o));

	task automatic conclude();
		if (fail_count == 0 && total_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : conclude

	task automatic check(input logic [31:0] seen, input logic [31:0] exp,
		input string what);
		total_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED at %0t: %s", $time, what);
		end
	endtask : check

	function automatic logic [31:0] rnd();
		return $random(seed);
	endfunction : rnd

	function automatic logic range_hit(input logic [ADDR_W-1:0] x,
		input logic out);
		return out ? (x < lo || x > hi) : (x >= lo && x <= hi);
	endfunction : range_hit

	function automatic logic data_ok(input logic [DATA_W-1:0] x,
		input logic iv);
		return ((x ^ {dh, dl}) & msk) == (iv ? msk : 16'h0000);
	endfunction : data_ok

	// address registers use three lanes, all others lane 0
	task automatic wb_xfer(input logic we, input logic [5:0] idx,
		input logic [31:0] wdat);
		int n;
		n = 0;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= {idx, 2'b00};
		wb_sel_i <= (idx[5:2] == 4'h9) ? 4'h7 : 4'h1;
		wb_dat_i <= wdat;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		if (n >= 20) fail_count++;
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk_i);
	endtask : wb_xfer

	task automatic setup(input logic [7:0] ca, input logic [7:0] cb,
		input logic [7:0] pair, input logic [7:0] trc);
		wb_xfer(1'b1, IDX_ARM, ZERO);
		wb_xfer(1'b1, IDX_CTL, {24'h00_0000, ca});
		wb_xfer(1'b1, IDX_CTL + 6'h01, {24'h00_0000, cb});
		wb_xfer(1'b1, IDX_PAIRING, {24'h00_0000, pair});
		wb_xfer(1'b1, IDX_TRACE, {24'h00_0000, trc});
		wb_xfer(1'b1, IDX_MASK_LOW, {24'h00_0000, msk[7:0]});
		wb_xfer(1'b1, IDX_MASK_HIGH, {24'h00_0000, msk[15:8]});
		wb_xfer(1'b1, IDX_ARM, ONE);
		check(32'(armed_o), ONE, "armed flag");
	endtask : setup

	initial begin
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		foreach (ridx[i]) begin
			wb_xfer(1'b0, ridx[i], ZERO);
			check(rd, ZERO, "value after reset");
		end
		dh = 8'(rnd());
		dl = 8'(rnd());
		wb_xfer(1'b1, IDX_DATA_HIGH, {24'h00_0000, dh});
		wb_xfer(1'b1, IDX_DATA_LOW, {24'h00_0000, dl});
		wb_xfer(1'b1, 6'h3f, 32'hffff_ffff);
		wb_xfer(1'b0, IDX_DATA_HIGH, ZERO);
		check(rd, {24'h00_0000, dh}, "data high readback");
		wb_xfer(1'b0, IDX_DATA_LOW, ZERO);
		check(rd, {24'h00_0000, dl}, "data low readback");
		wb_xfer(1'b0, 6'h3f, ZERO);
		check(rd, ZERO, "unmapped read");
		lo = 23'h00_1000 + 23'(rnd() & 32'h0000_0ffe);
		hi = lo + 23'h00_0040;
		wb_xfer(1'b1, IDX_ADDR, {9'h000, lo});
		wb_xfer(1'b1, IDX_ADDR + 6'h01, {9'h000, hi});
		// passes: inside, inside with data, outside with inverted data
		for (int p = 0; p < 3; p++) begin
			msk = (p == 0) ? 16'h0000 : 16'h00ff;
			inv = (p == 2);
			outside = (p == 2);
			setup({inv, 7'h3f}, 8'h03, outside ? 8'h05 : 8'h01, 8'h00);
			for (int n = 0; n < 24; n++) begin
				a = lo - 23'h00_0008 + 23'(rnd() % 96);
				d = 16'(rnd());
				d = d[0] ? ({dh, dl} ^ {16{inv}}) : d;
				f = {3'b000, 2'(rnd())};
				e = range_hit(a, outside) && !f[0] && data_ok(d, inv);
				i_model.bus_cycle(a, d, f);
				#1;
				check(32'(halt_o), 32'(e), "range halt");
			end
		end
		wb_xfer(1'b1, IDX_DATA_HIGH, {24'h00_0000, ~dh});
		wb_xfer(1'b0, IDX_DATA_HIGH, ZERO);
		check(rd, {24'h00_0000, dh}, "armed write");
		msk = 16'h0000;
		setup(8'h41, 8'h21, 8'h01, 8'h00);
		// odd byte just past the upper limit still shares its word
		i_model.bus_cycle(hi + 23'h00_0001, 16'h0000, 5'h04);
		#1;
		check(32'(tag_hit_o), ONE, "tagged fetch");
		check(32'(halt_o), ZERO, "second halt control");
		i_model.bus_cycle(lo + 23'h00_0002, 16'h0000, 5'h14);
		#1;
		check(32'(tag_hit_o), ZERO, "vector fetch tag");
		setup(8'h00, 8'h00, 8'h00, 8'h81);
		last = 23'h00_0000;
		for (int n = 0; n < 20; n++) begin
			k = 2'(rnd() % 3);
			a = (rnd() % 2 == 0) ? lo : hi;
			e = (k != COF_SOURCE) || (a != last);
			if (e) last = a;
			i_model.cof_event(k, a);
			#1;
			check(32'(trace_valid_o), 32'(e), "loop entry");
			if (e) check(32'(trace_addr_o), 32'(a), "loop addr");
		end
		setup(8'h00, 8'h00, 8'h00, 8'h82);
		for (int n = 0; n < 20; n++) begin
			a = 23'(rnd());
			d = 16'(rnd());
			f = {1'b0, 4'(rnd())};
			e = !f[2] && !f[3];
			i_model.bus_cycle(a, d, f);
			#1;
			check(32'(trace_valid_o), 32'(e), "detail entry");
			if (e) begin
				check(32'(trace_addr_o), 32'(a), "detail addr");
				check(32'(trace_data_o), 32'(d), "detail data");
				check(32'(trace_info_o), 32'({f[0], f[1]}), "info");
			end
		end
		setup(8'h00, 8'h00, 8'h00, 8'h83);
		for (int n = 0; n < 10; n++) begin
			a = 23'(rnd());
			i_model.exec_op(a);
			#1;
			check(32'(trace_valid_o), ONE, "pc entry");
			check(32'(trace_addr_o), 32'(a), "pc addr");
		end
		// cd outside range with lower limit zero; d controls must not count
		wb_xfer(1'b1, IDX_ADDR + 6'h02, ZERO);
		wb_xfer(1'b1, IDX_ADDR + 6'h03, {9'h000, hi});
		wb_xfer(1'b1, IDX_CTL + 6'h02, 32'h0000_0027);
		wb_xfer(1'b1, IDX_CTL + 6'h03, 32'h0000_0023);
		setup(8'h01, 8'h21, 8'h0b, 8'h00);
		for (int n = 0; n < 16; n++) begin
			a = hi - 23'h00_0010 + 23'(rnd() % 32);
			f = {3'b000, 2'(rnd())};
			e = a > hi && !f[0];
			i_model.bus_cycle(a, 16'(rnd()), f);
			#1;
			check(32'(halt_o), 32'(e), "cd halt");
		end
		wb_xfer(1'b1, IDX_CTL + 6'h03, 32'h0000_0022);
		i_model.bus_cycle(hi + 23'h00_0008, 16'h0000, 5'h00);
		#1;
		check(32'(halt_o), ZERO, "one pair enable");
		wb_xfer(1'b1, IDX_CTL + 6'h02, 32'h0000_0007);
		wb_xfer(1'b1, IDX_CTL + 6'h03, 32'h0000_0023);
		i_model.bus_cycle(hi + 23'h00_0008, 16'h0000, 5'h00);
		#1;
		check(32'(halt_o), ZERO, "d halt ignored");
		// detail trace limited to the c..d window
		setup(8'h00, 8'h00, 8'h00, 8'h86);
		i_model.bus_cycle(hi + 23'h00_0008, 16'h0000, 5'h00);
		#1;
		check(32'(trace_valid_o), ZERO, "outside window");
		i_model.bus_cycle(hi - 23'h00_0008, 16'h0000, 5'h00);
		#1;
		check(32'(trace_valid_o), ONE, "inside window");
		// normal mode keeps repeated sources
		setup(8'h00, 8'h00, 8'h00, 8'h80);
		repeat (2) begin
			i_model.cof_event(COF_SOURCE, lo);
			#1;
			check(32'(trace_valid_o), ONE, "normal repeat");
		end
		// single comparator with all data bits masked off
		setup(8'h21, 8'h00, 8'h00, 8'h00);
		i_model.bus_cycle(lo, 16'(rnd()), 5'h00);
		#1;
		check(32'(halt_o), ONE, "single unmasked");
		conclude();
	end

	initial begin
		repeat (20000) @(posedge clk_i);
		fail_count++;
		conclude();
	end
endmodule : testbench
